/* rtl/i2cm_ctrl.v */
/*
  single-master two-wire bus controller: start, restart and stop
  generation, msb-first byte shifting, 7- and 10-bit addressing,
  clock stretching, flag-driven pauses and one merged interrupt line.
  assumes: one clock domain on clk, scl/sda are open-drain pins with
  external pull-ups, the register port master never waits.
*/
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "i2cm_defs.vh"
// How it works
// - master only, never slave, no arbitration
// - baud divider reaches 400 kbit per second
// - 7- and 10-bit addresses, unlimited bytes
// - every bit goes out msb first
// - release scl, wait until it reads high
// - sda moves mid-low, sampled mid-high
// - four interrupt sources merged on irq
// - tx needs enable and txi; rest gated
// - nack flag set without start/stop, cleared
// - after nack wait for start or stop
// - rx full set in ack, read clears
// - read stalls until rx full cleared
// - tx empty set on listed events
// - data write clears tx empty
// - tx empty holds before ack cycle
// - no ack hold when start/stop set
// - disabled timer select gives baud interrupts
// - tx empty independent of txi
// - tx dma request only with txi
// - start needs start bit and data
// - start bit at end gives restart
// - flush drops byte, re-enables tx empty
// - send-nack set before last byte
// - stop bit cleared after stop sent
// - ack bit follows slave acknowledge
module i2cm_ctrl #(
  parameter BRW = 16                 // baud divider width
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  output reg        irq,
  output reg        tx_dma_req,
  output reg        rx_dma_req
);

  // controller states
  localparam S_IDLE = 3'd0;
  localparam S_STRT = 3'd1;
  localparam S_BIT  = 3'd2;
  localparam S_NEXT = 3'd3;
  localparam S_TXW  = 3'd4;
  localparam S_HOLD = 3'd5;
  localparam S_STOP = 3'd6;

  // byte kinds: first address, second 10-bit address, data
  localparam K_AD1 = 2'd0;
  localparam K_AD2 = 2'd1;
  localparam K_DAT = 2'd2;

  reg           en_q;                // controller_enable_bit
  reg           sta_q;               // start pending
  reg           sto_q;               // stop pending
  reg           tsel_q;              // timer_irq_select
  reg           txi_q;               // tx_irq_enable
  reg           snak_q;              // send-nack for next rx byte
  reg  [7:0]    data_q;              // data register, both ways
  reg           dfull_q;             // data register holds tx byte
  reg           txe_q;               // tx_empty_flag
  reg           rxf_q;               // rx_full_flag
  reg           ack_q;               // last acknowledge seen
  reg           rdir_q;              // read direction of transfer
  reg           ten_q;               // 10-bit address in use
  reg           nack_q;              // nack_flag
  reg           bflag_q;             // baud countdown hit
  reg  [BRW-1:0] brg_q;              // divider reload value
  reg  [BRW-1:0] bcnt_q;             // divider count
  reg  [2:0]    st_q;                // state
  reg  [1:0]    ph_q;                // quarter of a bit period
  reg  [3:0]    bit_q;               // bit in byte, 8 is ack
  reg  [7:0]    sh_q;                // shift register
  reg  [1:0]    kind_q;              // kind of current byte
  reg           scl_m_q;             // scl synchroniser first stage
  reg           scl_s_q;             // scl synchronised
  reg           sda_m_q;             // sda synchroniser first stage
  reg           sda_s_q;             // sda synchronised

  // divider runs for the bus or as a free timer
  wire run  = en_q | tsel_q;
  wire tick = run & (bcnt_q == {{(BRW-1){1'b0}}, 1'b1});
  // a quarter only ends past mid-high once scl really reads high
  wire step = tick & ((ph_q != 2'd2) | scl_s_q);
  wire rx   = rdir_q & (kind_q == K_DAT);
  wire wr_d = wr & (addr == `I2CM_OFF_DATA);
  wire wr_c = wr & (addr == `I2CM_OFF_CTRL);
  wire rd_d = rd & (addr == `I2CM_OFF_DATA);
  wire rd_s = rd & (addr == `I2CM_OFF_STAT);
  wire ends = sta_q | sto_q;         // no further byte follows
  // byte is one that software refills for
  wire txc  = (kind_q == K_AD2) | ~rdir_q | ((kind_q == K_AD1) & ten_q);

  // pin synchronisers; only the second stage is read
  always @(posedge clk) begin
    if (!rstn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  // baud divider: reload at one, a tick is one quarter bit
  always @(posedge clk) begin
    if (!rstn) begin
      bcnt_q <= `I2CM_RST_BRG;
    end else if (!run || bcnt_q <= {{(BRW-1){1'b0}}, 1'b1}) begin
      bcnt_q <= brg_q;
    end else begin
      bcnt_q <= bcnt_q - {{(BRW-1){1'b0}}, 1'b1};
    end
  end

  // registers and bus sequencer; later assignments win, so a
  // hardware set placed after a software clear takes priority
  always @(posedge clk) begin
    if (!rstn) begin
      en_q    <= 1'b0;
      sta_q   <= 1'b0;
      sto_q   <= 1'b0;
      tsel_q  <= 1'b0;
      txi_q   <= 1'b0;
      snak_q  <= 1'b0;
      data_q  <= `I2CM_RST_BYTE;
      dfull_q <= 1'b0;
      txe_q   <= 1'b0;
      rxf_q   <= 1'b0;
      ack_q   <= 1'b0;
      rdir_q  <= 1'b0;
      ten_q   <= 1'b0;
      nack_q  <= 1'b0;
      bflag_q <= 1'b0;
      brg_q   <= `I2CM_RST_BRG;
      st_q    <= S_IDLE;
      ph_q    <= 2'd0;
      bit_q   <= 4'd0;
      sh_q    <= 8'h00;
      kind_q  <= K_AD1;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      // software side of the register port
      if (wr_d) begin
        data_q  <= wdata;
        dfull_q <= 1'b1;
        txe_q   <= 1'b0;
      end
      if (rd_d)
        rxf_q <= 1'b0;
      if (rd_s)
        bflag_q <= 1'b0;
      if (wr & (addr == `I2CM_OFF_BRGH))
        brg_q[BRW-1:8] <= wdata[BRW-9:0];
      if (wr & (addr == `I2CM_OFF_BRGL))
        brg_q[7:0] <= wdata;
      if (wr_c) begin
        en_q   <= wdata[`I2CM_C_EN];
        sta_q  <= wdata[`I2CM_C_STA];
        sto_q  <= wdata[`I2CM_C_STO];
        tsel_q <= wdata[`I2CM_C_TSEL];
        txi_q  <= wdata[`I2CM_C_TXI];
        snak_q <= wdata[`I2CM_C_SNAK];
        // only setting start or stop ends a nack pause
        if (wdata[`I2CM_C_STA] | wdata[`I2CM_C_STO])
          nack_q <= 1'b0;
        // enabling with an empty data register asks for a byte
        if (wdata[`I2CM_C_EN] & ~en_q & ~dfull_q & ~wr_d)
          txe_q <= 1'b1;
        if (wdata[`I2CM_C_FLSH]) begin
          dfull_q <= 1'b0;
          txe_q   <= 1'b1;
        end
      end
      // free timer: only while disabled with timer select
      if (tick & ~en_q & tsel_q)
        bflag_q <= 1'b1;

      // bus sequencer, master only: no slave decode, no arbitration
      if (!en_q) begin
        st_q   <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        ph_q   <= 2'd0;
      end else begin
        case (st_q)
          S_IDLE: begin
            ph_q <= 2'd0;
            // a start waits for both the start bit and a byte
            if (sta_q & dfull_q)
              st_q <= S_STRT;
            else if (sto_q & ~sta_q)
              sto_q <= 1'b0;         // nothing open to stop
          end
          // start and restart: sda released, scl released, sda
          // pulled low while scl is high, then scl pulled low
          S_STRT: begin
            if (step) begin
              ph_q <= ph_q + 2'd1;
              case (ph_q)
                2'd0: sda_oe <= 1'b0;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b1;
                default: begin
                  scl_oe  <= 1'b1;
                  sta_q   <= 1'b0;
                  st_q    <= S_BIT;
                  bit_q   <= 4'd0;
                  kind_q  <= K_AD1;
                  sh_q    <= data_q;
                  dfull_q <= 1'b0;
                  rdir_q  <= data_q[0];
                  ten_q   <= data_q[7:3] == `I2CM_TEN_PFX;
                end
              endcase
            end
          end
          S_BIT: begin
            if (step) begin
              ph_q <= ph_q + 2'd1;
              case (ph_q)
                // middle of scl low: move sda
                2'd0: begin
                  if (bit_q == 4'd8 && !rx && txe_q && !ends) begin
                    st_q <= S_TXW;
                    ph_q <= 2'd0;
                  end else if (bit_q == 4'd8) begin
                    if (rx) begin
                      // master acknowledges unless told to nack
                      sda_oe <= ~snak_q;
                      data_q <= sh_q;
                      rxf_q  <= 1'b1;
                      if (snak_q & ~ends)
                        nack_q <= 1'b1;
                    end else begin
                      sda_oe <= 1'b0;
                    end
                  end else begin
                    sda_oe <= rx ? 1'b0 : ~sh_q[7];
                    // first bit of a byte software refills for
                    if (bit_q == 4'd0 && txc && !dfull_q)
                      txe_q <= 1'b1;
                  end
                end
                // end of low: let scl go
                2'd1: scl_oe <= 1'b0;
                // middle of high: sample sda
                2'd2: begin
                  if (bit_q != 4'd8) begin
                    sh_q <= {sh_q[6:0], sda_s_q};
                  end else if (!rx) begin
                    ack_q <= ~sda_s_q;
                    if (sda_s_q & ~ends)
                      nack_q <= 1'b1;
                  end
                end
                default: begin
                  scl_oe <= 1'b1;
                  if (bit_q == 4'd8)
                    st_q <= S_NEXT;
                  else
                    bit_q <= bit_q + 4'd1;
                end
              endcase
            end
          end
          // scl is held low here until the next step is known
          S_NEXT: begin
            ph_q  <= 2'd0;
            bit_q <= 4'd0;
            if (nack_q) begin
              st_q <= S_HOLD;
            end else if (rx && rxf_q) begin
              st_q <= S_NEXT;
            end else if (sto_q) begin
              st_q <= S_STOP;
            end else if (sta_q) begin
              // restart once a new address byte is waiting
              if (dfull_q)
                st_q <= S_STRT;
            end else if (rx || (kind_q == K_AD1 && rdir_q)) begin
              st_q   <= S_BIT;
              kind_q <= K_DAT;
              sda_oe <= 1'b0;
            end else if (dfull_q) begin
              st_q    <= S_BIT;
              sh_q    <= data_q;
              dfull_q <= 1'b0;
              kind_q  <= (kind_q == K_AD1 && ten_q) ? K_AD2 : K_DAT;
            end
          end
          // transmit byte owed: wait for data or an end request
          S_TXW: begin
            if (dfull_q | ends)
              st_q <= S_BIT;
          end
          // after a nack nothing moves until start or stop
          S_HOLD: begin
            if (ends)
              st_q <= S_NEXT;
          end
          // stop: sda low, scl released, sda released while high
          S_STOP: begin
            if (step) begin
              ph_q <= ph_q + 2'd1;
              case (ph_q)
                2'd0: sda_oe <= 1'b1;
                2'd1: scl_oe <= 1'b0;
                2'd2: sda_oe <= 1'b0;
                default: begin
                  sto_q <= 1'b0;
                  st_q  <= S_IDLE;
                end
              endcase
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // read data, interrupt and dma requests, all registered
  always @(posedge clk) begin
    if (!rstn) begin
      rdata      <= 8'h00;
      irq        <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      // open drain: only ever pull low, enables decide
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      // tx empty shows in status whatever txi says
      irq <= (en_q & ((txe_q & txi_q) | rxf_q | nack_q))
           | (tsel_q & bflag_q);
      tx_dma_req <= en_q & txi_q & txe_q;
      rx_dma_req <= en_q & rxf_q;
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `I2CM_OFF_DATA: rdata <= data_q;
          `I2CM_OFF_STAT: rdata <= {txe_q, rxf_q, ack_q, rdir_q,
                                    ten_q, nack_q, st_q != S_IDLE,
                                    bflag_q};
          `I2CM_OFF_CTRL: rdata <= {en_q, sta_q, sto_q, tsel_q,
                                    txi_q, snak_q, 2'b00};
          `I2CM_OFF_BRGH: rdata <= brg_q[BRW-1:8];
          `I2CM_OFF_BRGL: rdata <= brg_q[7:0];
          default:        rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // i2cm_ctrl

/* shared/i2cm_defs.vh */
/*
  register offsets, bit positions and reset values of the two-wire
  bus master controller.
  assumes: included by rtl/i2cm_ctrl.v only, by its bare name.
*/
`ifndef I2CM_DEFS_VH
`define I2CM_DEFS_VH

// register offsets on the 3-bit register port
`define I2CM_OFF_DATA 3'h0
`define I2CM_OFF_STAT 3'h1
`define I2CM_OFF_CTRL 3'h2
`define I2CM_OFF_BRGH 3'h3
`define I2CM_OFF_BRGL 3'h4

// control register bits
`define I2CM_C_EN   7
`define I2CM_C_STA  6
`define I2CM_C_STO  5
`define I2CM_C_TSEL 4
`define I2CM_C_TXI  3
`define I2CM_C_SNAK 2
`define I2CM_C_FLSH 1

// status register bits
`define I2CM_S_TXE  7
`define I2CM_S_RXF  6
`define I2CM_S_ACK  5
`define I2CM_S_RD   4
`define I2CM_S_TEN  3
`define I2CM_S_NAK  2
`define I2CM_S_BUSY 1
`define I2CM_S_BAUD 0

// reset values
`define I2CM_RST_BRG  16'h0010
`define I2CM_RST_BYTE 8'h00

// top five bits of a first address byte that opens a 10-bit address
`define I2CM_TEN_PFX 5'h1e

`endif

/* verification/i2cm_slave_model.sv */
/*
  behavioural two-wire slave: acks, shifts msb first, answers reads
  and stretches scl after every falling edge inside a frame.
  assumes resolved open-drain wires with pull-ups on scl and sda.
*/
`timescale 1ns/1ns
module i2cm_slave_model (
  input  wire       scl,
  input  wire       sda,
  input  wire       ack_en,
  input  wire [7:0] rd_byte,
  input  wire [3:0] stretch,
  output reg        sda_pull,
  output reg        scl_pull,
  output reg  [7:0] last_byte
);
  integer   bitn    = 9;     // bit slot, 9 means outside a frame
  reg       rdir    = 1'b0;  // read direction latched from address
  reg       addr_ph = 1'b1;  // first byte of a frame
  reg [7:0] sh      = 8'h00; // receive shifter
  initial begin
    sda_pull  = 1'b0;
    scl_pull  = 1'b0;
    last_byte = 8'h00;
  end
  // start or restart opens a frame
  always @(negedge sda) if (scl) begin
    bitn    = 0;
    addr_ph = 1'b1;
    rdir    = 1'b0;
  end
  // stop closes it
  always @(posedge sda) if (scl) bitn = 9;
  // sample on the rising edge, msb first
  always @(posedge scl) if (bitn < 9) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 7) last_byte = sh;
    if (bitn == 7 && addr_ph) rdir = sh[0];
    // a master nack ends our data so the stop is not blocked
    if (bitn == 8 && rdir && !addr_ph && sda) rdir = 1'b0;
    if (bitn == 8) addr_ph = 1'b0;
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end
  // drive the next slot, then hold scl low for a while
  always @(negedge scl) begin
    if (bitn == 8) sda_pull <= ack_en && !(rdir && !addr_ph);
    else if (bitn < 8) sda_pull <= rdir && !addr_ph && !rd_byte[7 - bitn];
    else sda_pull <= 1'b0;
    if (bitn < 9 && stretch != 4'h0) begin
      scl_pull = 1'b1;
      #(stretch * 40) scl_pull = 1'b0;
    end
  end
endmodule // i2cm_slave_model

/* verification/i2cm_ctrl_asserts.sv */
/*
  port checker of the two-wire master, bound into i2cm_ctrl.
  assumes the register map of the controller: control at offset 2,
  enable in bit 7, timer select in bit 4, tx interrupt enable in bit 3.
*/
`timescale 1ns/1ns
module i2cm_ctrl_asserts #(
  parameter BRW = 16
) (
  input wire       clk,
  input wire       rstn,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire       scl_in,
  input wire       scl_oe,
  input wire       sda_oe,
  input wire       irq,
  input wire       tx_dma_req,
  input wire       rx_dma_req
);
  reg en_q;   // shadow of the enable bit
  reg txi_q;  // shadow of the tx interrupt enable
  reg tsel_q; // shadow of the timer select
  // shadows follow control writes only
  always @(posedge clk)
    if (!rstn) begin
      en_q   <= 1'b0;
      txi_q  <= 1'b0;
      tsel_q <= 1'b0;
    end else if (wr && addr == 3'h2) begin
      en_q   <= wdata[7];
      tsel_q <= wdata[4];
      txi_q  <= wdata[3];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence seq_start;
    !scl_oe && $rose(sda_oe);
  endsequence
  sequence seq_stretch;
    !scl_oe && !scl_in;
  endsequence
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !rstn |=> !scl_oe && !sda_oe && !irq) else $error("busy after reset");
  AST_RDATA_ONE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_UNMAPPED: assert property (rd && addr > 3'h4 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_TXDMA_GATE: assert property (!txi_q && !$past(txi_q)
    |-> !tx_dma_req) else $error("tx dma without txi");
  AST_IRQ_GATE: assert property (!en_q && !tsel_q && !$past(en_q)
    && !$past(tsel_q) |-> !irq) else $error("irq while gated");
  AST_RX_CLEAR: assert property (rd && addr == 3'h0
    |-> ##2 !rx_dma_req) else $error("rx full not cleared by read");
  AST_SCL_WAIT: assert property (seq_stretch |=> !scl_oe)
    else $error("scl pulled during stretch");
  // disabling releases both lines at once, so only watch while enabled
  AST_SDA_STEADY: assert property (en_q && $changed(sda_oe)
    |-> $stable(scl_oe)) else $error("sda moved with scl");
  AST_START: assert property (seq_start |-> ##[1:64] scl_oe)
    else $error("start not followed by scl low");
endmodule // i2cm_ctrl_asserts

bind i2cm_ctrl i2cm_ctrl_asserts #(.BRW(BRW)) u_chk (.clk(clk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

/* verification/i2cm_master_controller_test.sv */
/*
  self-checking bench of the two-wire master with a slave model.
  assumes reload 2, so one bit lasts 10 clocks, 400 ns: the mid-high quarter waits an extra tick for the synchronised scl.
*/
`timescale 1ns/1ns
module i2cm_master_controller_test;
  reg        clk, rstn, wr, rd, ack_en;
  reg  [2:0] addr;
  reg  [7:0] wdata, rd_byte, ad, dat, v;
  reg  [3:0] stretch;
  wire [7:0] rdata, last_byte;
  wire       scl_oe, sda_oe, irq, tx_dma_req, rx_dma_req, scl_out, sda_out;
  wire       sda_pull, scl_pull;
  // open drain with pull-ups: an enabled pin shows its driven level
  wire       scl = !((scl_oe && !scl_out) || scl_pull);
  wire       sda = !((sda_oe && !sda_out) || sda_pull);
  integer    num_errors = 0, num_checks = 0, i;
  i2cm_ctrl u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  i2cm_slave_model u_slave (.scl(scl), .sda(sda), .ack_en(ack_en),
    .rd_byte(rd_byte), .stretch(stretch), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .last_byte(last_byte));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input string nm, input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wreg(input [2:0] a, input [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rreg(input [2:0] a, output [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // poll one bit, bounded so a hang shows as a mismatch
  task wait_bit(input [2:0] a, input integer b, input x);
    integer n;
    rreg(a, v);
    for (n = 0; n < 400 && v[b] !== x; n++) rreg(a, v);
    check("polled bit", {7'h00, v[b]}, {7'h00, x});
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    {rstn, wr, rd, addr, wdata, rd_byte, stretch} = 0;
    ack_en = 1'b1;
    void'($urandom(23745));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(3'h1, v); check("status", v, 8'h00);
    rreg(3'h4, v); check("baud low", v, 8'h10);
    for (i = 5; i < 8; i++) begin
      wreg(i[2:0], 8'hff);
      rreg(i[2:0], v); check("unmapped", v, 8'h00);
    end
    wreg(3'h4, 8'h02);
    wreg(3'h2, 8'h88);
    wait_bit(3'h1, 7, 1'b1);
    check("irq txi", {7'h00, irq}, 8'h01);
    check("tx dma", {7'h00, tx_dma_req}, 8'h01);
    wreg(3'h2, 8'h80);
    rreg(3'h1, v); check("tx empty", v & 8'h80, 8'h80);
    check("irq no txi", {7'h00, irq}, 8'h00);
    $display("test registers done");
    // writes, random address and data, slave stretching from the second
    for (i = 0; i < 3; i++) begin
      // the last pass opens with a 10-bit prefix, its 2nd byte is dat
      ad = (i == 2) ? (8'hf0 | ($urandom & 8'h06)) : ($urandom & 8'h7e);
      dat = $urandom;
      // lsb 0 so that the held last bit still shows on sda
      if (i == 1) dat = dat & 8'hfe;
      stretch <= i * 5;
      wreg(3'h0, ad);
      rreg(3'h1, v); check("empty cleared", v & 8'h80, 8'h00);
      wreg(3'h2, 8'hc8);
      wait_bit(3'h1, 7, 1'b1);
      wreg(3'h0, dat);
      wait_bit(3'h1, 7, 1'b1);
      if (i == 1) begin
        repeat (200) @(posedge clk);
        check("ack hold", {6'h00, scl_oe, sda_oe}, 8'h03);
      end
      wreg(3'h2, 8'ha0);
      wait_bit(3'h2, 5, 1'b0);
      check("slave byte", last_byte, dat);
      rreg(3'h1, v);
      check("ack", v & 8'h2c, (i == 2) ? 8'h28 : 8'h20);
    end
    $display("test write done");
    ack_en <= 1'b0;
    wreg(3'h0, 8'h52);
    wreg(3'h2, 8'hc0);
    // the next byte is queued before the nack, so flush has work
    wait_bit(3'h1, 7, 1'b1);
    wreg(3'h0, dat);
    wait_bit(3'h1, 2, 1'b1);
    check("nack irq", {7'h00, irq}, 8'h01);
    // let the ack bit finish its last quarter first
    repeat (4) @(posedge clk);
    v = {6'h00, scl_oe, sda_oe};
    repeat (100) @(posedge clk);
    check("bus frozen", {6'h00, scl_oe, sda_oe}, v);
    wreg(3'h2, 8'ha2);
    wait_bit(3'h2, 5, 1'b0);
    rreg(3'h1, v); check("flush", v & 8'ha4, 8'h80);
    $display("test nack done");
    ack_en <= 1'b1;
    rd_byte <= $urandom;
    wreg(3'h0, 8'ha7);
    wreg(3'h2, 8'hc0);
    wait_bit(3'h1, 6, 1'b1);
    check("rx dma", {7'h00, rx_dma_req}, 8'h01);
    repeat (100) @(posedge clk);
    check("rx stall", {6'h00, scl_oe, sda_oe}, 8'h03);
    wreg(3'h2, 8'h84);
    rreg(3'h0, v); check("rx data", v, rd_byte);
    wait_bit(3'h1, 2, 1'b1);
    rreg(3'h0, v); check("last data", v, rd_byte);
    wreg(3'h2, 8'ha0);
    wait_bit(3'h2, 5, 1'b0);
    $display("test read done");
    wreg(3'h4, 8'h40);
    wreg(3'h2, 8'h10);
    for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
    check("timer irq", {7'h00, irq}, 8'h01);
    rreg(3'h1, v); check("baud hit", v & 8'h01, 8'h01);
    rreg(3'h1, v); check("hit cleared", v & 8'h01, 8'h00);
    $display("test timer done");
    results;
  end
endmodule // i2cm_master_controller_test
